//--- shared/itest_pkg.sv
/*
 * integration test pin override: shared constants, register map, carriers.
 * assumes a 32-bit APB slave with 12-bit byte addressing and aligned words.
 */
`default_nettype none

package itest_pkg;

	// ------------------------------------------------------------
	// register map (byte addresses, one aligned word each)
	// ------------------------------------------------------------
	localparam int unsigned ADDR_W = 12;
	localparam logic [ADDR_W-1:0] OFS_MODE_CONTROL = 12'h000;
	localparam logic [ADDR_W-1:0] OFS_OUTPUT_DRIVE = 12'h004;
	localparam logic [ADDR_W-1:0] OFS_INPUT_SAMPLE = 12'h008;

	// ------------------------------------------------------------
	// field positions
	// ------------------------------------------------------------
	localparam int unsigned MODE_ENABLE_BIT = 0;
	localparam int unsigned DRV_RESTART_DONE_BIT = 9;
	localparam int unsigned DRV_MONITOR_IRQ_BIT = 4;
	localparam int unsigned DRV_HALT_ACK_BIT = 0;
	localparam int unsigned SMP_RESTART_REQ_BIT = 11;
	localparam int unsigned SMP_FAST_IRQ_BIT = 2;
	localparam int unsigned SMP_NORMAL_IRQ_BIT = 1;
	localparam int unsigned SMP_HALT_REQ_BIT = 0;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
	localparam logic RST_MODE = 1'h0;

	// overridable core outputs travel together
	typedef struct packed {
		logic restart_done;
		logic monitor_irq;
		logic halt_ack;
	} pins_t;

	localparam pins_t PINS_RESET = 3'h0;

	// register selected by an address
	typedef enum logic [3:0] {
		SEL_NONE = 4'h1,
		SEL_MODE = 4'h2,
		SEL_DRIVE = 4'h4,
		SEL_SAMPLE = 4'h8
	} reg_sel_t;

	// bus slave phase
	typedef enum logic [1:0] {
		ST_IDLE = 2'h1,
		ST_ACCESS = 2'h2
	} bus_state_t;

endpackage

`default_nettype wire

//--- hw/pin_override_sel.sv
/*
 * registered output stage: picks functional or test-driven pin values.
 * assumes mode and drive values come from the same clock domain.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_override_sel (
	// clock, reset and enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// selection
	input wire logic mode,
	input wire itest_pkg::pins_t drive,
	input wire itest_pkg::pins_t func,
	// pins
	output itest_pkg::pins_t pins_q
);

	// ------------------------------------------------------------
	// output flops
	// ------------------------------------------------------------

	// a flop here keeps the pins glitch-free across a mode change
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pins_q <= itest_pkg::PINS_RESET;
		end else if (ce) begin
			if (mode) begin
				pins_q <= drive; // [R3]
			end else begin
				pins_q <= func; // [R14]
			end
		end
	end

endmodule // pin_override_sel

`default_nettype wire

//--- hw/integration_test_pin_override.sv
/*
 * integration test pin override: APB register slave with mode control,
 * output drive and input sample registers, plus the pin override stage.
 * assumes synchronous pins, one clock, a well-behaved APB master.
 */
// Behaviour
// R1 - software sets the mode enable bit before touching drive or sample registers
// R2 - mode bit zero is normal operation, one is integration mode
// R3 - in integration mode written drive values replace the functional outputs
// R4 - drive bit 9 restart done, bit 4 monitor irq, bit 0 halt ack
// R5 - writers put zeros in unused drive register bits
// R6 - sample bit 11 returns the restart request level in integration mode
// R7 - sample bits 0,1,2 return halt request, normal irq, fast irq levels
// R8 - unused sample bits are undefined; they read as zero here
// R9 - core should be halted in debug state before integration testing
// R10 - mode must not be enabled until the core has halted
// R11 - the system is reset after an integration session
// R12 - mode control register is always accessible, others gated by mode
// R13 - intended pin changes are made effective together
// R14 - with mode zero outputs follow functional sources, drive contents ignored
// R15 - overridden outputs hold until rewritten or integration mode is left
`timescale 1ns/1ps
`default_nettype none

module integration_test_pin_override (
	// clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [itest_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// functional sources of the overridable outputs
	input wire logic restart_done_func,
	input wire logic monitor_irq_func,
	input wire logic halt_ack_func,
	// sampled core inputs
	input wire logic restart_request_in,
	input wire logic normal_irq_in_n,
	input wire logic fast_irq_in_n,
	input wire logic external_halt_request_in,
	// overridable core outputs and the mode enable indication
	output logic restart_done_out,
	output logic monitor_irq_out,
	output logic halt_ack_out,
	output logic test_mode_enable
);

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------

	// address decode, shared by the read and the write paths
	function automatic itest_pkg::reg_sel_t decode(input logic [itest_pkg::ADDR_W-1:0] a);
		itest_pkg::reg_sel_t s;
		s = itest_pkg::SEL_NONE;
		case (a)
			itest_pkg::OFS_MODE_CONTROL: s = itest_pkg::SEL_MODE;
			itest_pkg::OFS_OUTPUT_DRIVE: s = itest_pkg::SEL_DRIVE;
			itest_pkg::OFS_INPUT_SAMPLE: s = itest_pkg::SEL_SAMPLE;
			default: s = itest_pkg::SEL_NONE;
		endcase
		return s;
	endfunction

	// ------------------------------------------------------------
	// state
	// ------------------------------------------------------------
	itest_pkg::bus_state_t state_q, state_d;
	itest_pkg::reg_sel_t sel;
	itest_pkg::pins_t drive_q, drive_wr, func, pins_q;
	logic mode_q;
	logic pready_q;
	logic pslverr_q;
	logic [31:0] prdata_q;
	logic [31:0] sample_word;
	logic setup;
	logic commit;
	logic gated;

	assign sel = decode(paddr);
	assign setup = psel & ~penable & (state_q == itest_pkg::ST_IDLE);
	assign commit = psel & penable & pready_q;
	// drive and sample are refused while the mode bit is clear
	assign gated = ~mode_q & ((sel == itest_pkg::SEL_DRIVE) | (sel == itest_pkg::SEL_SAMPLE));

	// ------------------------------------------------------------
	// bus phase machine
	// ------------------------------------------------------------

	// one wait-free access phase; ce low freezes state_q and pready_q as they are
	always_comb begin
		state_d = state_q;
		case (state_q)
			itest_pkg::ST_IDLE: begin
				if (setup) begin
					state_d = itest_pkg::ST_ACCESS;
				end
			end
			itest_pkg::ST_ACCESS: begin
				if (commit) begin
					state_d = itest_pkg::ST_IDLE;
				end
			end
			default: state_d = itest_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= itest_pkg::ST_IDLE;
			pready_q <= 1'h0;
		end else if (ce) begin
			state_q <= state_d;
			pready_q <= (state_d == itest_pkg::ST_ACCESS);
		end
	end

	// ------------------------------------------------------------
	// read data and error, captured in the setup cycle
	// ------------------------------------------------------------

	// pins sampled at read time; unused positions read as zero
	always_comb begin
		sample_word = itest_pkg::WORD_ZERO; // [R8]
		sample_word[itest_pkg::SMP_RESTART_REQ_BIT] = restart_request_in; // [R6]
		sample_word[itest_pkg::SMP_FAST_IRQ_BIT] = fast_irq_in_n; // [R7]
		sample_word[itest_pkg::SMP_NORMAL_IRQ_BIT] = normal_irq_in_n; // [R7]
		sample_word[itest_pkg::SMP_HALT_REQ_BIT] = external_halt_request_in; // [R7]
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= itest_pkg::WORD_ZERO;
			pslverr_q <= 1'h0;
		end else if (ce && setup) begin
			prdata_q <= itest_pkg::WORD_ZERO;
			pslverr_q <= (sel == itest_pkg::SEL_NONE) | gated; // [R12]
			if (!pwrite) begin
				case (sel)
					itest_pkg::SEL_MODE: prdata_q[itest_pkg::MODE_ENABLE_BIT] <= mode_q; // [R12]
					itest_pkg::SEL_SAMPLE: prdata_q <= mode_q ? sample_word : itest_pkg::WORD_ZERO;
					default: prdata_q <= itest_pkg::WORD_ZERO; // drive is write-only
				endcase
			end
		end
	end

	// ------------------------------------------------------------
	// mode control register
	// ------------------------------------------------------------

	// always writable; takes effect at the commit edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_q <= itest_pkg::RST_MODE;
		end else if (ce && commit && pwrite && sel == itest_pkg::SEL_MODE) begin
			mode_q <= pwdata[itest_pkg::MODE_ENABLE_BIT]; // [R2] [R12]
		end
	end

	// ------------------------------------------------------------
	// output drive register
	// ------------------------------------------------------------
	assign drive_wr.restart_done = pwdata[itest_pkg::DRV_RESTART_DONE_BIT]; // [R4]
	assign drive_wr.monitor_irq = pwdata[itest_pkg::DRV_MONITOR_IRQ_BIT]; // [R4]
	assign drive_wr.halt_ack = pwdata[itest_pkg::DRV_HALT_ACK_BIT]; // [R4]

	// cleared on leaving the mode so a later entry starts from a known state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			drive_q <= itest_pkg::PINS_RESET;
		end else if (ce) begin
			if (!mode_q) begin
				drive_q <= itest_pkg::PINS_RESET; // [R15]
			end else if (commit && pwrite && sel == itest_pkg::SEL_DRIVE) begin
				drive_q <= drive_wr; // [R4] [R15]
			end
		end
	end

	// ------------------------------------------------------------
	// output stage
	// ------------------------------------------------------------
	assign func.restart_done = restart_done_func;
	assign func.monitor_irq = monitor_irq_func;
	assign func.halt_ack = halt_ack_func;

	pin_override_sel u_sel (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.mode(mode_q),
		.drive(drive_q),
		.func(func),
		.pins_q(pins_q)
	);

	assign restart_done_out = pins_q.restart_done;
	assign monitor_irq_out = pins_q.monitor_irq;
	assign halt_ack_out = pins_q.halt_ack;
	assign test_mode_enable = mode_q;
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	sequence s_mode_write;
		ce && commit && pwrite && sel == itest_pkg::SEL_MODE;
	endsequence

	sequence s_drive_write;
		ce && commit && pwrite && sel == itest_pkg::SEL_DRIVE && mode_q;
	endsequence

	a_mode_decode: assert property (@(posedge pclk) disable iff (!presetn) // [R2]
		s_mode_write |=> mode_q == $past(pwdata[0]))
		else $error("mode bit not taken from write");

	a_drive_reaches_pin: assert property (@(posedge pclk) disable iff (!presetn) // [R3]
		s_drive_write ##1 (ce && mode_q) |=> halt_ack_out == $past(pwdata[0], 2))
		else $error("halt ack pin does not follow drive write");

	a_drive_bit_map: assert property (@(posedge pclk) disable iff (!presetn) // [R4]
		s_drive_write |=> drive_q.restart_done == $past(pwdata[9])
			&& drive_q.monitor_irq == $past(pwdata[4]))
		else $error("drive register bit mapping wrong");

	a_sample_restart: assert property (@(posedge pclk) disable iff (!presetn) // [R6]
		ce && setup && !pwrite && sel == itest_pkg::SEL_SAMPLE && mode_q
		|=> prdata_q[11] == $past(restart_request_in))
		else $error("sample bit 11 wrong");

	a_sample_irqs: assert property (@(posedge pclk) disable iff (!presetn) // [R7]
		ce && setup && !pwrite && sel == itest_pkg::SEL_SAMPLE && mode_q
		|=> prdata_q[2:0] == $past({fast_irq_in_n, normal_irq_in_n, external_halt_request_in}))
		else $error("sample bits 2 to 0 wrong");

	a_sample_unused: assert property (@(posedge pclk) disable iff (!presetn) // [R8]
		ce && setup && !pwrite && sel == itest_pkg::SEL_SAMPLE
		|=> prdata_q[31:12] == 20'h0 && prdata_q[10:3] == 8'h0)
		else $error("unused sample bits not zero");

	a_gated_error: assert property (@(posedge pclk) disable iff (!presetn) // [R12]
		ce && setup |=> pready_q && pslverr_q == $past(gated || sel == itest_pkg::SEL_NONE))
		else $error("access answer or error wrong");

	a_functional_out: assert property (@(posedge pclk) disable iff (!presetn) // [R14]
		// sampled presetn skips the release edge, where the pins still show reset
		ce && presetn && !mode_q |=> {restart_done_out, monitor_irq_out, halt_ack_out}
			== $past({restart_done_func, monitor_irq_func, halt_ack_func}))
		else $error("outputs not functional in normal mode");

	a_drive_hold: assert property (@(posedge pclk) disable iff (!presetn) // [R15]
		mode_q && !(ce && commit && pwrite && sel == itest_pkg::SEL_DRIVE)
		|=> drive_q == $past(drive_q) || !$past(ce))
		else $error("drive value changed without write");

endmodule // integration_test_pin_override

`default_nettype wire

//--- test/debug_agent.sv
/*
 * partner model: the external debugger acting as apb master.
 * assumes the caller enters xfer right after a rising edge of pclk.
 */
`timescale 1ns/1ps
`default_nettype none

module debug_agent (
	// clock
	input wire logic pclk,
	// apb master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [itest_pkg::ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
	end

	// whole words only; callers keep reserved drive bits zero
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic e, output logic ok);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1);
		// only the bench watchdog ends a wait; ok flags a zero-wait answer
		ok = (n == 1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines carry garbage so stale values cannot pass
		paddr <= ~a;
		pwdata <= ~d;
	endtask
endmodule // debug_agent

`default_nettype wire

//--- test/integration_test_pin_override_tb.sv
/*
 * self-checking bench for the integration test pin override block.
 * assumes the debug_agent partner drives the apb side.
 */
`timescale 1ns/1ps
`default_nettype none

module integration_test_pin_override_tb;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic rdo, mio, hao, mode;
	logic [3:0] pin_in;
	itest_pkg::pins_t func;
	int fails, checked;

	// 200 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end

	debug_agent agent (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	integration_test_pin_override uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .restart_done_func(func.restart_done),
		.monitor_irq_func(func.monitor_irq), .halt_ack_func(func.halt_ack),
		.restart_request_in(pin_in[3]), .fast_irq_in_n(pin_in[2]),
		.normal_irq_in_n(pin_in[1]), .external_halt_request_in(pin_in[0]),
		.restart_done_out(rdo), .monitor_irq_out(mio), .halt_ack_out(hao),
		.test_mode_enable(mode));

	task finish_test;
		$display("checks %0d mismatches %0d", checked, fails);
		if (fails == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// one bus access judged on zero-wait answer, error flag and, for reads, data
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [31:0] x,
		input logic xe);
		logic [31:0] r;
		logic e, ok;
		agent.xfer(w, a, d, r, e, ok);
		check("pready", {31'h0, ok}, 32'h1);
		check("pslverr", {31'h0, e}, {31'h0, xe});
		if (!w) check("prdata", r, x);
	endtask

	// pins settle one edge after the commit edge
	task pins(input logic [2:0] x);
		repeat (2) @(posedge pclk);
		#1;
		check("pins", {29'h0, rdo, mio, hao}, {29'h0, x});
	endtask

	task t_normal;
		check("mode", {31'h0, mode}, 32'h0);
		acc(1'b0, itest_pkg::OFS_MODE_CONTROL, 32'h0, 32'h0, 1'b0);
		@(posedge pclk) func <= 3'h5;
		pins(3'h5);
		acc(1'b1, itest_pkg::OFS_OUTPUT_DRIVE, 32'h211, 32'h0, 1'b1);
		acc(1'b0, itest_pkg::OFS_INPUT_SAMPLE, 32'h0, 32'h0, 1'b1);
		acc(1'b0, 12'hffc, 32'h0, 32'h0, 1'b1);
		pins(3'h5);
		$display("test normal done");
	endtask

	// ce low freezes the pins while the functional source moves
	task t_freeze;
		@(posedge pclk) func <= 3'h3;
		pins(3'h3);
		@(posedge pclk) begin
			ce <= 1'b0;
			func <= 3'h4;
		end
		pins(3'h3);
		@(posedge pclk) ce <= 1'b1;
		pins(3'h4);
		$display("test freeze done");
	endtask

	task automatic t_drive;
		logic [31:0] v[5] = '{32'h201, 32'h010, 32'h001, 32'h000, 32'h211};
		// core halted first: functional halt ack high
		@(posedge pclk) func <= 3'h7;
		acc(1'b1, itest_pkg::OFS_MODE_CONTROL, 32'h1, 32'h0, 1'b0);
		acc(1'b0, itest_pkg::OFS_MODE_CONTROL, 32'h0, 32'h1, 1'b0);
		check("mode", {31'h0, mode}, 32'h1);
		foreach (v[i]) begin
			acc(1'b1, itest_pkg::OFS_OUTPUT_DRIVE, v[i], 32'h0, 1'b0);
			pins({v[i][9], v[i][4], v[i][0]});
		end
		@(posedge pclk) func <= 3'h0;
		pins(3'h7);
		acc(1'b0, itest_pkg::OFS_OUTPUT_DRIVE, 32'h0, 32'h0, 1'b0);
		$display("test drive done");
	endtask

	task t_sample;
		for (int i = 0; i < 16; i++) begin
			@(posedge pclk) pin_in <= i[3:0];
			acc(1'b0, itest_pkg::OFS_INPUT_SAMPLE, 32'h0, {20'h0, i[3], 8'h0, i[2:0]}, 1'b0);
		end
		acc(1'b1, itest_pkg::OFS_INPUT_SAMPLE, 32'hfff, 32'h0, 1'b0);
		$display("test sample done");
	endtask

	task t_leave;
		acc(1'b1, itest_pkg::OFS_MODE_CONTROL, 32'h0, 32'h0, 1'b0);
		@(posedge pclk) func <= 3'h2;
		pins(3'h2);
		acc(1'b1, itest_pkg::OFS_MODE_CONTROL, 32'h1, 32'h0, 1'b0);
		pins(3'h0);
		// system reset closes the session
		@(posedge pclk) presetn <= 1'b0;
		@(posedge pclk) presetn <= 1'b1;
		#1;
		check("mode", {31'h0, mode}, 32'h0);
		$display("test leave done");
	endtask

	// watchdog well beyond the expected run
	initial begin
		#50000;
		fails++;
		finish_test();
	end

	initial begin
		fails = 0;
		checked = 0;
		presetn = 1'b0;
		ce = 1'b1;
		func = 3'h0;
		pin_in = 4'h0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_normal();
		t_freeze();
		t_drive();
		t_sample();
		t_leave();
		finish_test();
	end
endmodule // integration_test_pin_override_tb

`default_nettype wire
